// >>> cfb_pkg.sv
// Package: register map, field layout, types and timing for the function blocks
package cfb_pkg;

  // Linear values are signed hundredths of a percent (10000 = 100.00%)
  localparam int VAL_W = 16;
  typedef logic signed [VAL_W-1:0] cfb_val_t;

  // Classic Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } cfb_wb_req_t;

  // Multi-function transfer functions, encoded 0 to 6 in this order
  typedef enum logic [2:0] {
    MODE_PASS, MODE_CMP, MODE_AND, MODE_OR, MODE_INV, MODE_NEG, MODE_ABS
  } cfb_mode_t;

  // Timing: clock period and sample period
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Parameter numbers and limits
  localparam logic [9:0] PIN_DISCONNECT = 10'h190;
  localparam logic [9:0] AUX_SRC_MAX = 10'h2D0;
  localparam logic [15:0] HYST_MAX = 16'h03E8;

  // Register byte addresses
  localparam logic [7:0] OFS_MF_CFG = 8'h00;
  localparam logic [7:0] OFS_MF_MAIN = 8'h04;
  localparam logic [7:0] OFS_MF_AUX = 8'h08;
  localparam logic [7:0] OFS_MF_AUXSRC = 8'h0C;
  localparam logic [7:0] OFS_MF_OUT = 8'h10;
  localparam logic [7:0] OFS_LT_CTL = 8'h14;
  localparam logic [7:0] OFS_LT_HI = 8'h18;
  localparam logic [7:0] OFS_LT_LO = 8'h1C;
  localparam logic [7:0] OFS_LT_OUT = 8'h20;
  localparam logic [7:0] OFS_CN_CTL = 8'h24;
  localparam logic [7:0] OFS_CN_TGT = 8'h28;
  localparam logic [7:0] OFS_CN_STAT = 8'h2C;
  localparam logic [7:0] OFS_TM_CTL = 8'h30;
  localparam logic [7:0] OFS_TM_IVL = 8'h34;
  localparam logic [7:0] OFS_TM_STAT = 8'h38;
  localparam logic [7:0] OFS_CP_MODE = 8'h3C;
  localparam logic [7:0] OFS_CP_IN1 = 8'h40;
  localparam logic [7:0] OFS_CP_IN2 = 8'h44;
  localparam logic [7:0] OFS_CP_HYST = 8'h48;
  localparam logic [7:0] OFS_CP_DEST = 8'h4C;
  localparam logic [7:0] OFS_CP_OUT = 8'h50;
  localparam logic [7:0] OFS_SW_CTL = 8'h54;
  localparam logic [7:0] OFS_SW_HI = 8'h58;
  localparam logic [7:0] OFS_SW_LO = 8'h5C;
  localparam logic [7:0] OFS_SW_DEST = 8'h60;
  localparam logic [7:0] OFS_SW_OUT = 8'h64;
  localparam logic [7:0] OFS_DX_SEL = 8'h68;
  localparam logic [7:0] OFS_DX_OUT = 8'h6C;

  // Field positions
  localparam int MF_MODE_LSB = 0;
  localparam int MF_OPSEL_BIT = 3;
  localparam int LT_DATA_BIT = 0;
  localparam int LT_CLK_BIT = 1;
  localparam int LT_SET_BIT = 2;
  localparam int LT_RST_BIT = 3;
  localparam int CN_CLK_BIT = 0;
  localparam int CN_RST_BIT = 1;
  localparam int STAT_FLAG_BIT = 16;
  localparam int SW_CTL_BIT = 0;
  localparam int SW_FB_BIT = 1;

  // Reset values
  localparam logic [15:0] LT_HI_RST = 16'h2710;
  localparam logic [15:0] CN_TGT_RST = 16'h000A;
  localparam logic [15:0] TM_IVL_RST = 16'h000A;

endpackage

// >>> cfb_blocks.sv
// Sampled logic function blocks with a Wishbone register slave
// Notes on behaviour
// - Enabled output select gives chosen transfer function
// - Invert mode output is main XOR select
// - Aux source accepts 0..720, 400 disconnects
// - Linear value is logic 0 only at zero
// - Mode codes: pass, cmp, and, or, inv, neg, abs
// - Latch loads data on rising clock input
// - Latch drives high value or low value
// - Counter increments on each rising clock input
// - Counter held at zero while reset high
// - Target flag high when count reaches target
// - New target leaves count undisturbed
// - Timer runs while disabled, clears when enabled
// - Expired stays high until enable cycle
// - Comparator high when input 1 exceeds input 2
// - Hysteresis limited to 0 to 10.00 percent
// - Hysteresis band on both switching thresholds
// - Window mode high strictly inside plus/minus input 2
// - Window hysteresis at both boundaries
// - Comparator and switch idle with destination 400
// - Switch passes high or low input by control
// - Fed-back switch holds last value when low
// - Alarm word split into sixteen flags
// - Alarm word from active or stored alarms
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module cfb_blocks #(
  parameter int SAMPLE_CYCLES = cfb_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cfb_pkg::cfb_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] active_alarm_i,
  input wire logic [15:0] stored_alarm_i,
  output logic [15:0] alarm_flag_o
);
  import cfb_pkg::*;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Linear value seen as a logic level
  function automatic logic lvl(input cfb_val_t v);
    lvl = (v != '0);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Sample tick
  localparam int TW = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYCLES - 1);
  logic [TW-1:0] tick_cnt_r;
  logic tick;
  assign tick = (tick_cnt_r == TICK_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic req, wr, ack_r;
  assign req = wb_req_i.cyc && wb_req_i.stb && !ack_r;
  assign wr = req && wb_req_i.we;

  logic [3:0] mf_cfg_r;
  logic [15:0] mf_main_r, mf_aux_r, mf_out_r;
  logic [9:0] aux_src_r;
  logic [3:0] lt_ctl_r;
  logic [15:0] lt_hi_r, lt_lo_r, lt_out_r;
  logic lt_q_r;
  logic [1:0] cn_ctl_r;
  logic [15:0] cn_tgt_r, cn_cnt_r;
  logic cn_flag_r;
  logic tm_en_r, tm_exp_r;
  logic [15:0] tm_ivl_r, tm_el_r;
  logic cp_win_r, cp_out_r;
  logic [15:0] cp_in1_r, cp_in2_r, cp_hyst_r;
  logic [9:0] cp_dest_r, sw_dest_r;
  logic [1:0] sw_ctl_r;
  logic [15:0] sw_hi_r, sw_lo_r, sw_out_r;
  logic dx_sel_r;
  logic [15:0] wd;
  logic [15:0] wd_merged;
  logic [9:0] wd10;
  assign wd = wb_req_i.dat[15:0];
  // Lane-merged write word; source numbers use its low ten bits
  assign wd_merged = wr16(16'h0000, wb_req_i.dat, wb_req_i.sel);
  assign wd10 = wd_merged[9:0];

  // Acknowledge one cycle after each request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end
  assign wb_ack_o = ack_r;

  // Configuration registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf_cfg_r <= '0;
      mf_main_r <= '0;
      mf_aux_r <= '0;
      aux_src_r <= PIN_DISCONNECT;
      lt_ctl_r <= '0;
      lt_hi_r <= LT_HI_RST;
      lt_lo_r <= '0;
      cn_ctl_r <= '0;
      cn_tgt_r <= CN_TGT_RST;
      tm_en_r <= 1'b1;
      tm_ivl_r <= TM_IVL_RST;
      cp_win_r <= 1'b0;
      cp_in1_r <= '0;
      cp_in2_r <= '0;
      cp_hyst_r <= '0;
      cp_dest_r <= PIN_DISCONNECT;
      sw_ctl_r <= '0;
      sw_hi_r <= '0;
      sw_lo_r <= '0;
      sw_dest_r <= PIN_DISCONNECT;
      dx_sel_r <= 1'b0;
    end else if (wr) begin
      case (wb_req_i.adr)
        OFS_MF_CFG: if (wb_req_i.sel[0]) mf_cfg_r <= wd[3:0];
        OFS_MF_MAIN: mf_main_r <= wr16(mf_main_r, wb_req_i.dat, wb_req_i.sel);
        OFS_MF_AUX: mf_aux_r <= wr16(mf_aux_r, wb_req_i.dat, wb_req_i.sel);
        OFS_MF_AUXSRC: if (wd10 <= AUX_SRC_MAX) aux_src_r <= wd10;
        OFS_LT_CTL: if (wb_req_i.sel[0]) lt_ctl_r <= wd[3:0];
        OFS_LT_HI: lt_hi_r <= wr16(lt_hi_r, wb_req_i.dat, wb_req_i.sel);
        OFS_LT_LO: lt_lo_r <= wr16(lt_lo_r, wb_req_i.dat, wb_req_i.sel);
        OFS_CN_CTL: if (wb_req_i.sel[0]) cn_ctl_r <= wd[1:0];
        OFS_CN_TGT: cn_tgt_r <= wr16(cn_tgt_r, wb_req_i.dat, wb_req_i.sel);
        OFS_TM_CTL: if (wb_req_i.sel[0]) tm_en_r <= wd[0];
        OFS_TM_IVL: tm_ivl_r <= wr16(tm_ivl_r, wb_req_i.dat, wb_req_i.sel);
        OFS_CP_MODE: if (wb_req_i.sel[0]) cp_win_r <= wd[0];
        OFS_CP_IN1: cp_in1_r <= wr16(cp_in1_r, wb_req_i.dat, wb_req_i.sel);
        OFS_CP_IN2: cp_in2_r <= wr16(cp_in2_r, wb_req_i.dat, wb_req_i.sel);
        OFS_CP_HYST: begin
          cp_hyst_r <= (wr16(cp_hyst_r, wb_req_i.dat, wb_req_i.sel) > HYST_MAX)
                       ? HYST_MAX : wr16(cp_hyst_r, wb_req_i.dat, wb_req_i.sel);
        end
        OFS_CP_DEST: if (wd10 <= AUX_SRC_MAX) cp_dest_r <= wd10;
        OFS_SW_CTL: if (wb_req_i.sel[0]) sw_ctl_r <= wd[1:0];
        OFS_SW_HI: sw_hi_r <= wr16(sw_hi_r, wb_req_i.dat, wb_req_i.sel);
        OFS_SW_LO: sw_lo_r <= wr16(sw_lo_r, wb_req_i.dat, wb_req_i.sel);
        OFS_SW_DEST: if (wd10 <= AUX_SRC_MAX) sw_dest_r <= wd10;
        OFS_DX_SEL: if (wb_req_i.sel[0]) dx_sel_r <= wd[0];
        default: ;
      endcase
    end
  end

  // Read data, zero for unmapped addresses
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    case (wb_req_i.adr)
      OFS_MF_CFG: rd = {28'h0, mf_cfg_r};
      OFS_MF_MAIN: rd = {16'h0, mf_main_r};
      OFS_MF_AUX: rd = {16'h0, mf_aux_r};
      OFS_MF_AUXSRC: rd = {22'h0, aux_src_r};
      OFS_MF_OUT: rd = {16'h0, mf_out_r};
      OFS_LT_CTL: rd = {28'h0, lt_ctl_r};
      OFS_LT_HI: rd = {16'h0, lt_hi_r};
      OFS_LT_LO: rd = {16'h0, lt_lo_r};
      OFS_LT_OUT: rd = {15'h0, lt_q_r, lt_out_r};
      OFS_CN_CTL: rd = {30'h0, cn_ctl_r};
      OFS_CN_TGT: rd = {16'h0, cn_tgt_r};
      OFS_CN_STAT: rd = {15'h0, cn_flag_r, cn_cnt_r};
      OFS_TM_CTL: rd = {31'h0, tm_en_r};
      OFS_TM_IVL: rd = {16'h0, tm_ivl_r};
      OFS_TM_STAT: rd = {15'h0, tm_exp_r, tm_el_r};
      OFS_CP_MODE: rd = {31'h0, cp_win_r};
      OFS_CP_IN1: rd = {16'h0, cp_in1_r};
      OFS_CP_IN2: rd = {16'h0, cp_in2_r};
      OFS_CP_HYST: rd = {16'h0, cp_hyst_r};
      OFS_CP_DEST: rd = {22'h0, cp_dest_r};
      OFS_CP_OUT: rd = {31'h0, cp_out_r};
      OFS_SW_CTL: rd = {30'h0, sw_ctl_r};
      OFS_SW_HI: rd = {16'h0, sw_hi_r};
      OFS_SW_LO: rd = {16'h0, sw_lo_r};
      OFS_SW_DEST: rd = {22'h0, sw_dest_r};
      OFS_SW_OUT: rd = {16'h0, sw_out_r};
      OFS_DX_SEL: rd = {31'h0, dx_sel_r};
      OFS_DX_OUT: rd = {16'h0, alarm_flag_o};
      default: rd = '0;
    endcase
  end

  // Read data captured with the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_req_i.we) begin
      wb_dat_o <= rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Multi-function block
  cfb_mode_t mode;
  cfb_val_t main_v, aux_v, mf_nxt;
  logic lm, la, opsel;
  assign mode = cfb_mode_t'(mf_cfg_r[MF_MODE_LSB +: 3]);
  assign opsel = mf_cfg_r[MF_OPSEL_BIT];
  assign main_v = cfb_val_t'(mf_main_r);
  // source 400 reads as disconnected (zero)
  assign aux_v = (aux_src_r == PIN_DISCONNECT) ? '0 : cfb_val_t'(mf_aux_r);
  // only exact zero is logic 0
  assign lm = lvl(main_v);
  assign la = lvl(aux_v);

  always_comb begin
    mf_nxt = main_v;
    case (mode)
      MODE_PASS: if (opsel) mf_nxt = aux_v;
      MODE_CMP: if (opsel) mf_nxt = cfb_val_t'(main_v > aux_v);
      MODE_AND: if (opsel) mf_nxt = cfb_val_t'(lm && la);
      MODE_OR: if (opsel) mf_nxt = cfb_val_t'(lm || la);
      // invert output is main XOR select
      MODE_INV: mf_nxt = cfb_val_t'(lm ^ opsel);
      MODE_NEG: begin
        if (opsel) begin
          mf_nxt = (main_v == 16'sh8000) ? 16'sh7FFF : -main_v;
        end
      end
      MODE_ABS: begin
        if (opsel && main_v < 0) begin
          mf_nxt = (main_v == 16'sh8000) ? 16'sh7FFF : -main_v;
        end
      end
      default: mf_nxt = main_v;
    endcase
  end

  // output updated at the sample tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf_out_r <= '0;
    end else if (tick) begin
      mf_out_r <= mf_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Latch
  logic lt_clk_prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lt_q_r <= 1'b0;
      lt_clk_prev_r <= 1'b0;
    end else if (tick) begin
      lt_clk_prev_r <= lt_ctl_r[LT_CLK_BIT];
      // reset then set override the clock
      if (lt_ctl_r[LT_RST_BIT]) begin
        lt_q_r <= 1'b0;
      end else if (lt_ctl_r[LT_SET_BIT]) begin
        lt_q_r <= 1'b1;
      // load on rising clock since last sample
      end else if (lt_ctl_r[LT_CLK_BIT] && !lt_clk_prev_r) begin
        lt_q_r <= lt_ctl_r[LT_DATA_BIT];
      end
    end
  end

  // output stage value for high or low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lt_out_r <= '0;
    end else begin
      lt_out_r <= lt_q_r ? lt_hi_r : lt_lo_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Batch counter
  logic cn_clk_prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cn_cnt_r <= '0;
      cn_clk_prev_r <= 1'b0;
    end else if (tick) begin
      cn_clk_prev_r <= cn_ctl_r[CN_CLK_BIT];
      // held at zero while reset high
      if (cn_ctl_r[CN_RST_BIT]) begin
        cn_cnt_r <= '0;
      end else if (cn_ctl_r[CN_CLK_BIT] && !cn_clk_prev_r) begin
        cn_cnt_r <= cn_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cn_flag_r <= 1'b0;
    end else begin
      cn_flag_r <= (cn_cnt_r >= cn_tgt_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interval timer, counting in sample periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tm_el_r <= '0;
      tm_exp_r <= 1'b0;
    end else if (tick) begin
      if (tm_en_r) begin
        tm_el_r <= '0;
        tm_exp_r <= 1'b0;
      // expire and hold until next enable
      end else if (tm_el_r >= tm_ivl_r) begin
        tm_exp_r <= 1'b1;
      end else begin
        tm_el_r <= tm_el_r + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Comparator, 18-bit arithmetic avoids overflow
  logic signed [17:0] c1, c2, ch, up_on, up_off, lo_on, lo_off;
  logic cp_nxt;
  assign c1 = 18'(cfb_val_t'(cp_in1_r));
  assign c2 = 18'(cfb_val_t'(cp_in2_r));
  assign ch = 18'(cp_hyst_r);
  assign up_on = c2 - ch;
  assign up_off = c2 + ch;
  assign lo_on = -c2 + ch;
  assign lo_off = -c2 - ch;

  always_comb begin
    cp_nxt = cp_out_r;
    if (cp_win_r) begin
      if (!cp_out_r && c1 < up_on && c1 > lo_on) begin
        cp_nxt = 1'b1;
      end else if (cp_out_r && (c1 >= up_off || c1 <= lo_off)) begin
        cp_nxt = 1'b0;
      end
    end else begin
      // high above input 2 plus hysteresis, low at or below input 2 minus it
      if (!cp_out_r && c1 > up_off) begin
        cp_nxt = 1'b1;
      end else if (cp_out_r && c1 <= up_on) begin
        cp_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cp_out_r <= 1'b0;
    end else if (cp_dest_r == PIN_DISCONNECT) begin
      cp_out_r <= 1'b0;
    end else if (tick) begin
      cp_out_r <= cp_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Changeover switch
  logic [15:0] sw_low_in;
  // feedback makes a sample and hold
  assign sw_low_in = sw_ctl_r[SW_FB_BIT] ? sw_out_r : sw_lo_r;

  // control picks high or low input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_out_r <= '0;
    end else if (sw_dest_r == PIN_DISCONNECT) begin
      sw_out_r <= '0;
    end else if (tick) begin
      sw_out_r <= sw_ctl_r[SW_CTL_BIT] ? sw_hi_r : sw_low_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Alarm word demultiplexer
  // active or stored alarm word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_flag_o <= '0;
    end else begin
      alarm_flag_o <= dx_sel_r ? stored_alarm_i : active_alarm_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cnt_edge;
    tick && !cn_ctl_r[CN_RST_BIT] && cn_ctl_r[CN_CLK_BIT] && !cn_clk_prev_r;
  endsequence
  sequence s_sw_high;
    tick && sw_dest_r != PIN_DISCONNECT && sw_ctl_r[SW_CTL_BIT];
  endsequence

  property p_aux_range;
    aux_src_r <= AUX_SRC_MAX;
  endproperty
  a_aux_range: assert property (p_aux_range) else $error("aux source out of range");
  property p_mf_inv;
    tick && mode == MODE_INV |=> mf_out_r == 16'($past(lm ^ opsel));
  endproperty
  a_mf_inv: assert property (p_mf_inv) else $error("invert output wrong");
  property p_lt_reset;
    tick && lt_ctl_r[LT_RST_BIT] |=> !lt_q_r ##1 lt_out_r == $past(lt_lo_r);
  endproperty
  a_lt_reset: assert property (p_lt_reset) else $error("latch reset failed");
  property p_cn_inc;
    s_cnt_edge |=> cn_cnt_r == $past(cn_cnt_r) + 16'h0001;
  endproperty
  a_cn_inc: assert property (p_cn_inc) else $error("count missed edge");
  property p_cn_rst;
    tick && cn_ctl_r[CN_RST_BIT] |=> cn_cnt_r == 16'h0000;
  endproperty
  a_cn_rst: assert property (p_cn_rst) else $error("count not cleared");
  property p_cn_flag;
    ##1 cn_flag_r == ($past(cn_cnt_r) >= $past(cn_tgt_r));
  endproperty
  a_cn_flag: assert property (p_cn_flag) else $error("target flag wrong");
  property p_cn_hold;
    !tick |=> cn_cnt_r == $past(cn_cnt_r);
  endproperty
  a_cn_hold: assert property (p_cn_hold) else $error("count moved off tick");
  property p_tm_clear;
    tick && tm_en_r |=> tm_el_r == 16'h0000 && !tm_exp_r;
  endproperty
  a_tm_clear: assert property (p_tm_clear) else $error("timer not cleared");
  property p_hyst_range;
    cp_hyst_r <= HYST_MAX;
  endproperty
  a_hyst_range: assert property (p_hyst_range) else $error("hysteresis too big");
  property p_cp_idle;
    cp_dest_r == PIN_DISCONNECT |=> !cp_out_r;
  endproperty
  a_cp_idle: assert property (p_cp_idle) else $error("comparator not idle");
  property p_sw_high;
    s_sw_high |=> sw_out_r == $past(sw_hi_r);
  endproperty
  a_sw_high: assert property (p_sw_high) else $error("switch not high input");
  property p_dx;
    ##1 alarm_flag_o == (dx_sel_r ? $past(stored_alarm_i) : $past(active_alarm_i))
      || $changed(dx_sel_r);
  endproperty
  a_dx: assert property (p_dx) else $error("alarm flags wrong");

endmodule

`default_nettype wire

// >>> cfb_blocks_tb.sv
// Self-checking testbench for the sampled logic function blocks
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module cfb_blocks_tb;
  import cfb_pkg::*;
  localparam int SC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  cfb_wb_req_t wb_req = '0;
  logic [31:0] wb_dat;
  logic wb_ack;
  logic [15:0] act_alarm = 16'h0000;
  logic [15:0] sto_alarm = 16'h0000;
  logic [15:0] alarm_flag;
  int n_fail = 0;
  int num_checks = 0;
  logic [15:0] mf_exp [7];
  logic [24:0] cp_tab [18];

  ////////////////////////////////////////
  // Short sample period keeps the run brief
  cfb_blocks #(.SAMPLE_CYCLES(SC)) u_cfb_blocks (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(wb_req),
    .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack),
    .active_alarm_i(act_alarm),
    .stored_alarm_i(sto_alarm),
    .alarm_flag_o(alarm_flag)
  );

  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One classic cycle, held until ack is sampled high; watchdog ends a hang
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    wb_req <= '{1'b1, 1'b1, we, 4'hF, a, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask

  // Write, then let two sample periods pass
  task automatic ws(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2 * SC) @(posedge clk_i);
  endtask

  // Read and compare value plus flag bit
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q & 32'h0001FFFF, e)
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    test_done();
  end

  ////////////////////////////////////////
  // Main sequence
  initial begin
    mf_exp = '{16'h3, 16'h0, 16'h1, 16'h1, 16'h0, 16'h5, 16'h5};
    cp_tab = '{{OFS_CP_IN1, 16'h041A, 1'b0}, {OFS_CP_IN1, 16'h044D, 1'b1},
      {OFS_CP_IN1, 16'h03B6, 1'b1}, {OFS_CP_IN1, 16'h0384, 1'b0},
      {OFS_CP_MODE, 16'h0001, 1'b0}, {OFS_CP_HYST, 16'h0000, 1'b1},
      {OFS_CP_IN1, 16'h03E8, 1'b0}, {OFS_CP_IN1, 16'hFC19, 1'b1},
      {OFS_CP_IN1, 16'hFC18, 1'b0}, {OFS_CP_HYST, 16'h0064, 1'b0},
      {OFS_CP_IN1, 16'h0352, 1'b1}, {OFS_CP_IN1, 16'h041A, 1'b1},
      {OFS_CP_IN1, 16'h044C, 1'b0}, {OFS_CP_IN1, 16'h03B6, 1'b0},
      {OFS_CP_IN1, 16'hFCAE, 1'b1}, {OFS_CP_IN1, 16'hFBB4, 1'b0},
      {OFS_CP_IN1, 16'h0000, 1'b1}, {OFS_CP_DEST, 16'h0190, 1'b0}};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and an unmapped place
    rc(OFS_MF_AUXSRC, {22'h0, PIN_DISCONNECT});
    rc(OFS_CP_DEST, {22'h0, PIN_DISCONNECT});
    rc(OFS_SW_DEST, {22'h0, PIN_DISCONNECT});
    rc(OFS_LT_HI, {16'h0, LT_HI_RST});
    rc(OFS_CN_TGT, {16'h0, CN_TGT_RST});
    rc(OFS_TM_IVL, {16'h0, TM_IVL_RST});
    rc(8'hFC, 32'h0);
    // Multi-function: disconnected aux, source limits, all modes
    ws(OFS_MF_MAIN, 32'hFFFB);
    ws(OFS_MF_AUX, 32'h0003);
    ws(OFS_MF_CFG, 32'h8);
    rc(OFS_MF_OUT, 32'h0);
    ws(OFS_MF_AUXSRC, 32'h2D1);
    rc(OFS_MF_AUXSRC, 32'h190);
    ws(OFS_MF_AUXSRC, 32'h2D0);
    rc(OFS_MF_AUXSRC, 32'h2D0);
    for (int m = 0; m < 7; m++) begin
      ws(OFS_MF_CFG, 32'h8 | m);
      rc(OFS_MF_OUT, {16'h0, mf_exp[m]});
    end
    ws(OFS_MF_CFG, 32'h4);
    rc(OFS_MF_OUT, 32'h1);
    ws(OFS_MF_MAIN, 32'h0);
    ws(OFS_MF_CFG, 32'hC);
    rc(OFS_MF_OUT, 32'h1);
    // Latch: clocked data, no edge, set and reset
    ws(OFS_LT_LO, 32'h5);
    ws(OFS_LT_CTL, 32'h1);
    ws(OFS_LT_CTL, 32'h3);
    rc(OFS_LT_OUT, 32'h12710);
    ws(OFS_LT_CTL, 32'h2);
    rc(OFS_LT_OUT, 32'h12710);
    ws(OFS_LT_CTL, 32'h0);
    ws(OFS_LT_CTL, 32'h2);
    rc(OFS_LT_OUT, 32'h00005);
    ws(OFS_LT_CTL, 32'h4);
    rc(OFS_LT_OUT, 32'h12710);
    ws(OFS_LT_CTL, 32'hC);
    rc(OFS_LT_OUT, 32'h00005);
    // Batch counter: count to target, retarget, held reset
    ws(OFS_CN_TGT, 32'h3);
    repeat (3) begin
      ws(OFS_CN_CTL, 32'h1);
      ws(OFS_CN_CTL, 32'h0);
    end
    rc(OFS_CN_STAT, 32'h10003);
    ws(OFS_CN_TGT, 32'h4);
    rc(OFS_CN_STAT, 32'h00003);
    ws(OFS_CN_CTL, 32'h1);
    rc(OFS_CN_STAT, 32'h10004);
    ws(OFS_CN_CTL, 32'h2);
    ws(OFS_CN_CTL, 32'h3);
    rc(OFS_CN_STAT, 32'h00000);
    ws(OFS_CN_CTL, 32'h0);
    // Interval timer: early clear, expiry, hold, clear
    ws(OFS_TM_IVL, 32'h5);
    ws(OFS_TM_CTL, 32'h0);
    ws(OFS_TM_CTL, 32'h1);
    rc(OFS_TM_STAT, 32'h0);
    ws(OFS_TM_CTL, 32'h0);
    repeat (4 * SC) @(posedge clk_i);
    rc(OFS_TM_STAT, 32'h10005);
    repeat (4 * SC) @(posedge clk_i);
    rc(OFS_TM_STAT, 32'h10005);
    ws(OFS_TM_CTL, 32'h1);
    rc(OFS_TM_STAT, 32'h0);
    // Comparator: hysteresis limit, plain, window, disconnect
    ws(OFS_CP_DEST, 32'h1);
    ws(OFS_CP_HYST, 32'h7D0);
    rc(OFS_CP_HYST, {16'h0, HYST_MAX});
    ws(OFS_CP_HYST, 32'h64);
    ws(OFS_CP_IN2, 32'h3E8);
    foreach (cp_tab[i]) begin
      ws(cp_tab[i][24:17], {16'h0, cp_tab[i][16:1]});
      rc(OFS_CP_OUT, {31'h0, cp_tab[i][0]});
    end
    // Changeover switch, plain and fed back
    ws(OFS_SW_DEST, 32'h1);
    ws(OFS_SW_HI, 32'h64);
    ws(OFS_SW_LO, 32'hC8);
    rc(OFS_SW_OUT, 32'hC8);
    ws(OFS_SW_CTL, 32'h1);
    rc(OFS_SW_OUT, 32'h64);
    ws(OFS_SW_CTL, 32'h3);
    ws(OFS_SW_HI, 32'h12C);
    rc(OFS_SW_OUT, 32'h12C);
    ws(OFS_SW_CTL, 32'h2);
    ws(OFS_SW_HI, 32'h32);
    rc(OFS_SW_OUT, 32'h12C);
    // Alarm demultiplexer: both sources, every stored bit
    act_alarm <= 16'hA5C3;
    sto_alarm <= 16'h5A3C;
    ws(OFS_DX_SEL, 32'h0);
    `CHK(alarm_flag, 16'hA5C3)
    rc(OFS_DX_OUT, 32'hA5C3);
    ws(OFS_DX_SEL, 32'h1);
    `CHK(alarm_flag, 16'h5A3C)
    for (int b = 0; b < 16; b++) begin
      sto_alarm <= 16'h0001 << b;
      repeat (3) @(posedge clk_i);
      `CHK(alarm_flag, 16'h0001 << b)
    end
    test_done();
  end
endmodule
`default_nettype wire
